// >>> common/vsd_regs.vh
/*
 * Timing constants of the video sync field decoder.
 * Assumes a 125 MHz ref_clk; times are in nanoseconds.
 */
// Contract
// - At serration start, integrator between two thresholds starts the vertical pulse.
// - Vertical pulse lasts exactly eight oscillator periods, then clears.
// - Without serration, integrator reaching default threshold starts the vertical pulse.
// - Default pulse ending early: sync interval end may launch a second pulse.
// - Default delay must exceed the vertical sync interval when starting at its end.
// - Field detector times gaps; a full horizontal gap clears the field flip-flop.
// - Short gaps in vertical interval toggle the field flip-flop on each pulse.
// - Field index comes from field flip-flop sampled by the vertical pulse.
// - Field index is low in even fields, high in odd fields.
// - Odd field starts at first equalizing pulse, even at the second.
// - Burst gate goes low on sync trailing edge and stays low 4 us.
`ifndef VSD_REGS_VH
`define VSD_REGS_VH

`define VSD_CLK_PERIOD_NS     8
`define VSD_BURST_TIME_NS     4000
`define VSD_BURST_CYCLES      ((`VSD_BURST_TIME_NS + `VSD_CLK_PERIOD_NS - 1) / `VSD_CLK_PERIOD_NS)
`define VSD_OSC_PERIODS       8
`define VSD_OSC_CYCLES        2656
`define VSD_FIRST_THRESH      1500
`define VSD_DEFAULT_THRESH    6400
`define VSD_HGAP_THRESH       6000
`define VSD_CNT_W             16

`endif

// >>> hdl/vsd_pulse_timer.v
/*
 * One-shot timer: a start pulse holds busy for a fixed cycle count.
 * Assumes start comes from logic on the same clock.
 */
module vsd_pulse_timer #(
    parameter WIDTH  = 16,
    parameter CYCLES = 500
) (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst_b,
    input  wire clk_en,
    // Control
    input  wire start,
    output reg  busy
);

    localparam integer     LAST_I = CYCLES - 1;
    localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];
    reg [WIDTH-1:0] count;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy  <= 1'b0;
            count <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            if (start) begin
                busy  <= 1'b1;
                count <= {WIDTH{1'b0}};
            end else if (busy) begin
                if (count == LAST)
                    busy <= 1'b0;
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // vsd_pulse_timer

// >>> hdl/vsd_sync_decoder.v
/*
 * Composite sync decoder: vertical pulse, odd/even index, burst gate.
 * Assumes csync is an asynchronous pin, high during sync pulses,
 * and a 125 MHz ref_clk.
 */
`include "vsd_regs.vh"

module vsd_sync_decoder #(
    parameter CNT_W          = `VSD_CNT_W,
    parameter FIRST_THRESH   = `VSD_FIRST_THRESH,
    parameter DEFAULT_THRESH = `VSD_DEFAULT_THRESH,
    parameter HGAP_THRESH    = `VSD_HGAP_THRESH,
    parameter OSC_CYCLES     = `VSD_OSC_CYCLES,
    parameter OSC_PERIODS    = `VSD_OSC_PERIODS
) (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst_b,
    input  wire clk_en,
    // Sync input
    input  wire csync,
    // Decoded outputs
    output reg  vert_out,
    output reg  field_odd,
    output reg  burst_gate_b,
    output reg  sync_out
);

    localparam integer     OSC_LAST_I = OSC_CYCLES - 1;
    localparam integer     PER_LAST_I = OSC_PERIODS - 1;
    localparam [CNT_W-1:0] FIRST_T   = FIRST_THRESH[CNT_W-1:0];
    localparam [CNT_W-1:0] DEFAULT_T = DEFAULT_THRESH[CNT_W-1:0];
    localparam [CNT_W-1:0] HGAP_T    = HGAP_THRESH[CNT_W-1:0];
    localparam [CNT_W-1:0] OSC_LAST  = OSC_LAST_I[CNT_W-1:0];
    localparam [3:0]       PER_LAST  = PER_LAST_I[3:0];
    localparam [CNT_W-1:0] ONE       = {{(CNT_W-1){1'b0}}, 1'b1};

    // Vertical state machine, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    function at_limit;
        input [CNT_W-1:0] value;
        input [CNT_W-1:0] limit;
        begin
            at_limit = (value >= limit);
        end
    endfunction

    //------------------------------------------------------------
    // Input synchroniser
    //------------------------------------------------------------
    reg [2:0] sync_pipe;
    reg       sync_lvl;
    wire      agree = (sync_pipe[1] == sync_pipe[2]);
    wire      next_sync_lvl = agree ? sync_pipe[2] : sync_lvl;
    wire      sync_rise = next_sync_lvl & ~sync_lvl;
    wire      sync_fall = ~next_sync_lvl & sync_lvl;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_pipe <= 3'h0;
            sync_lvl  <= 1'b0;
        end else if (clk_en) begin
            sync_pipe <= {sync_pipe[1:0], csync};
            sync_lvl  <= next_sync_lvl;
        end
    end

    //------------------------------------------------------------
    // Vertical integrator and pulse
    //------------------------------------------------------------
    reg [CNT_W-1:0] integ;
    reg [CNT_W-1:0] osc_cnt;
    reg [3:0]       periods;
    reg [2:0]       state;
    reg             default_fired;

    wire above_first   = at_limit(integ, FIRST_T);
    wire above_default = at_limit(integ, DEFAULT_T);
    // End of a sync-tip level: serration start or end of vertical sync
    wire edge_trigger  = sync_fall & above_first;
    wire dflt_trigger  = sync_lvl & above_default & ~default_fired;
    wire osc_wrap      = (osc_cnt == OSC_LAST);

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            integ         <= {CNT_W{1'b0}};
            osc_cnt       <= {CNT_W{1'b0}};
            periods       <= 4'h0;
            state         <= ST_IDLE;
            default_fired <= 1'b0;
            vert_out      <= 1'b0;
        end else if (clk_en) begin
            if (!sync_lvl)
                integ <= {CNT_W{1'b0}};
            else if (!above_default)
                integ <= integ + ONE;
            if (!sync_lvl)
                default_fired <= 1'b0;
            else if (dflt_trigger)
                default_fired <= 1'b1;
            case (state)
                ST_IDLE: begin
                    if (edge_trigger || dflt_trigger) begin
                        state    <= ST_RUN;
                        vert_out <= 1'b1;
                        osc_cnt  <= {CNT_W{1'b0}};
                        periods  <= 4'h0;
                    end
                end
                ST_RUN: begin
                    osc_cnt <= osc_wrap ? {CNT_W{1'b0}} : osc_cnt + ONE;
                    if (osc_wrap) begin
                        periods <= periods + 4'h1;
                        if (periods == PER_LAST) begin
                            vert_out <= 1'b0;
                            state    <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // Early end of a default pulse: retrigger at interval end
                    if (edge_trigger || dflt_trigger) begin
                        state    <= ST_RUN;
                        vert_out <= 1'b1;
                        osc_cnt  <= {CNT_W{1'b0}};
                        periods  <= 4'h0;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state    <= ST_IDLE;
                    vert_out <= 1'b0;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Field detector
    //------------------------------------------------------------
    reg [CNT_W-1:0] gap_cnt;
    reg             field_ff;
    reg             vert_d;
    wire            gap_full = at_limit(gap_cnt, HGAP_T);

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt   <= {CNT_W{1'b0}};
            field_ff  <= 1'b0;
            vert_d    <= 1'b0;
            field_odd <= 1'b0;
            sync_out  <= 1'b0;
        end else if (clk_en) begin
            sync_out <= sync_lvl;
            vert_d   <= vert_out;
            if (sync_lvl)
                gap_cnt <= {CNT_W{1'b0}};
            else if (!gap_full)
                gap_cnt <= gap_cnt + ONE;
            if (gap_full)
                field_ff <= 1'b0;
            else if (sync_rise)
                field_ff <= ~field_ff;
            if (vert_out && !vert_d)
                field_odd <= field_ff;
        end
    end

    //------------------------------------------------------------
    // Burst gate / back porch
    //------------------------------------------------------------
    wire burst_busy;

    vsd_pulse_timer #(
        .WIDTH  (CNT_W),
        .CYCLES (`VSD_BURST_CYCLES)
    ) u_burst (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .start   (sync_fall),
        .busy    (burst_busy)
    );

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            burst_gate_b <= 1'b1;
        else if (clk_en)
            burst_gate_b <= ~(burst_busy | sync_fall);
    end

endmodule // vsd_sync_decoder

// >>> test/vsd_sync_decoder_properties.sv
/* Timing checker for vsd_sync_decoder.
   Assumes binding to every decoder instance, ports only. */
module vsd_sync_decoder_properties #(
    parameter int FIRST_THRESH   = 1500,
    parameter int DEFAULT_THRESH = 6400,
    parameter int OSC_CYCLES     = 2656,
    parameter int OSC_PERIODS    = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Decoder outputs
    input wire vert_out,
    input wire field_odd,
    input wire burst_gate_b,
    input wire sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VW = OSC_PERIODS * OSC_CYCLES;
    logic [15:0] hcnt, vcnt, bcnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ------
    // Tip length, pulse length, time since sync end
    // ------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hcnt <= 16'h0000;
            vcnt <= 16'h0000;
            bcnt <= 16'h0000;
        end else begin
            hcnt <= sync_out ? hcnt + 16'h0001 : 16'h0000;
            vcnt <= vert_out ? vcnt + 16'h0001 : 16'h0000;
            bcnt <= $fell(sync_out) ? 16'h0000 : bcnt + {15'h0000, bcnt != 16'hffff};
        end
    end
    a_vert_width: assert property ($fell(vert_out) |-> vcnt == VW)
        else $error("vertical pulse width wrong");
    a_burst_width: assert property ($rose(burst_gate_b) |-> bcnt inside {[499:503]})
        else $error("burst gate width wrong");
    a_burst_start: assert property ($fell(sync_out) |-> ##[0:2] !burst_gate_b)
        else $error("burst gate not started");
    a_field_moment: assert property ($changed(field_odd) |-> $past(vert_out) && !$past(vert_out, 2))
        else $error("field index changed off vertical start");
    a_vert_edge: assert property ($fell(sync_out) && hcnt > FIRST_THRESH && hcnt <= DEFAULT_THRESH
        && !$past(vert_out, 2) |-> vert_out)
        else $error("serration trigger missed");
    a_vert_default: assert property (sync_out && hcnt == DEFAULT_THRESH - 1 && !vert_out
        |-> ##[0:3] vert_out)
        else $error("default trigger missed");
    a_vert_retrig: assert property ($fell(sync_out) && hcnt > DEFAULT_THRESH
        && !$past(vert_out, 2) |-> vert_out)
        else $error("second pulse missed");
    a_short_ignored: assert property ($fell(sync_out) && hcnt < FIRST_THRESH
        && !$past(vert_out, 2) |-> !vert_out [*3])
        else $error("short tip started vertical pulse");
    c_vert: cover property ($rose(vert_out));
    c_field: cover property ($changed(field_odd));
    c_retrig: cover property ($fell(sync_out) && hcnt > DEFAULT_THRESH && !$past(vert_out, 2));
endmodule // vsd_sync_decoder_properties

bind vsd_sync_decoder vsd_sync_decoder_properties #(.FIRST_THRESH(FIRST_THRESH),
    .DEFAULT_THRESH(DEFAULT_THRESH), .OSC_CYCLES(OSC_CYCLES), .OSC_PERIODS(OSC_PERIODS))
    u_props (.ref_clk(ref_clk), .rst_b(rst_b), .vert_out(vert_out), .field_odd(field_odd),
    .burst_gate_b(burst_gate_b), .sync_out(sync_out));

// >>> test/vsd_sync_source.sv
/* Composite sync source and downstream line selector facing the decoder.
   Assumes csync is sampled on ref_clk rising edges. */
module vsd_sync_source (
    // Clock
    input  wire  ref_clk,
    // Sync stream
    output logic csync
);
    timeunit 1ns;
    timeprecision 1ps;
    initial csync = 1'b0;
    // ------
    // Level held a whole number of cycles, set just after an edge
    // ------
    task automatic drive(input logic level, input int cycles);
        @(posedge ref_clk);
        #1 csync = level;
        repeat (cycles - 1) @(posedge ref_clk);
        #1;
    endtask
endmodule // vsd_sync_source

module vsd_line_selector #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // Decoder outputs
    input  wire       sync_out,
    input  wire       vert_out,
    input  wire       field_odd,
    input  wire       burst_gate_b,
    // Selection
    input  wire       use_field,
    input  wire       want_odd,
    input  wire [7:0] line_sel,
    // Gates
    output logic      line_gate,
    output logic      black_gate
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CW = 4 * STAGES;
    logic [CW-1:0] cnt;
    logic          armed;
    logic          half;
    logic          load_d;
    logic          sync_d;
    wire           load_src = use_field ? (field_odd ^ want_odd) : vert_out;
    assign black_gate = !burst_gate_b && !line_gate;
    // ------
    // Down counter loaded on the falling load edge
    // ------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt       <= '0;
            armed     <= 1'b0;
            half      <= 1'b0;
            line_gate <= 1'b0;
            load_d    <= 1'b0;
            sync_d    <= 1'b0;
        end else begin
            load_d <= load_src;
            sync_d <= sync_out;
            if (load_d && !load_src) begin
                cnt       <= CW'(line_sel);
                armed     <= 1'b1;
                half      <= 1'b0;
                line_gate <= 1'b0;
            end else if (armed && sync_d != sync_out) begin
                cnt  <= cnt - 1'b1;
                half <= line_gate;
                if (cnt == 1)
                    line_gate <= 1'b1;
                if (line_gate && half) begin
                    line_gate <= 1'b0;
                    armed     <= 1'b0;
                end
            end
        end
    end
endmodule // vsd_line_selector

// >>> test/tb_video_sync_field_decoder.sv
/* Self-checking bench for vsd_sync_decoder.
   Assumes the bound checker and the sync source model. */
module tb_video_sync_field_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FT = 20;
    localparam int DT = 60;
    logic ref_clk = 1'b0;
    logic rst_b   = 1'b0;
    logic clk_en  = 1'b1;
    wire  csync, vert_out, field_odd, burst_gate_b, sync_out;
    wire  line_gate, black_gate;
    int   n_errors = 0;
    int   n_compared = 0;
    int   eq;
    always #4 ref_clk = ~ref_clk;
    vsd_sync_decoder #(.FIRST_THRESH(FT), .DEFAULT_THRESH(DT), .HGAP_THRESH(50),
        .OSC_CYCLES(10), .OSC_PERIODS(8)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_en(clk_en), .csync(csync), .vert_out(vert_out), .field_odd(field_odd),
        .burst_gate_b(burst_gate_b), .sync_out(sync_out));
    vsd_sync_source src (.ref_clk(ref_clk), .csync(csync));
    vsd_line_selector u_sel (.ref_clk(ref_clk), .rst_b(rst_b), .sync_out(sync_out),
        .vert_out(vert_out), .field_odd(field_odd), .burst_gate_b(burst_gate_b),
        .use_field(1'b0), .want_odd(1'b0), .line_sel(8'h04), .line_gate(line_gate),
        .black_gate(black_gate));
    task automatic check(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Field flop parity after short-gap rises
    function automatic logic exp_field(input int shorts);
        return shorts % 2 == 1;
    endfunction
    task automatic final_report;
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tip(input int hi, input int lo);
        src.drive(1'b1, hi);
        src.drive(1'b0, lo);
    endtask
    // ------
    // Equalizing pulses, then a serrated vertical tip
    // ------
    task automatic vblank(input int n, input logic gate_exp);
        int vt;
        vt = FT + 2 + int'($urandom % (DT - FT - 6));
        tip(4, 600);
        tip(3, 30);
        check("line_gate", gate_exp, line_gate);
        repeat (n - 1) tip(3, 30);
        check("line_gate", 1'b0, line_gate);
        tip(vt, 8);
        check("vert_out", 1'b1, vert_out);
        check("field_odd", exp_field(n), field_odd);
        src.drive(1'b0, 700);
        check("vert_out", 1'b0, vert_out);
    endtask
    initial begin
        void'($urandom(14));
        repeat (4) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (10) begin
            tip(2 + int'($urandom % 10), 8);
            check("burst_gate_b", 1'b0, burst_gate_b);
            check("black_gate", 1'b1, black_gate);
            src.drive(1'b0, 520 + int'($urandom % 200));
            check("burst_gate_b", 1'b1, burst_gate_b);
            check("vert_out", 1'b0, vert_out);
        end
        eq = 4 + int'($urandom % 4);
        vblank(eq, 1'b0);
        vblank(eq + 1, 1'b1);
        tip(70, 8);
        check("vert_out", 1'b1, vert_out);
        check("field_odd", exp_field(0), field_odd);
        src.drive(1'b0, 700);
        src.drive(1'b1, 170);
        check("vert_out", 1'b0, vert_out);
        tip(30, 8);
        check("vert_out", 1'b1, vert_out);
        src.drive(1'b0, 700);
        final_report;
    end
    initial begin
        #(8 * 40000);
        n_errors++;
        final_report;
    end
endmodule // tb_video_sync_field_decoder
